// ---- hms_homing.sv ----
// homing sequencer for methods 29 to 35 with register port
`timescale 1ns/1ns
module hms_homing (
	input  wire logic                       sys_clk_i,
	input  wire logic                       sys_rst_i,
	input  wire logic [hms_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [hms_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [hms_pkg::DATA_W-1:0] rdata_o,
	input  wire logic                       home_switch_i,
	input  wire logic                       positive_travel_limit_i,
	input  wire logic                       negative_travel_limit_i,
	input  wire logic                       index_pulse_i,
	input  wire logic                       motion_stopped_i,
	input  wire logic [hms_pkg::POS_W-1:0]  enc_pos_i,
	output logic                            move_fwd_o,
	output logic                            move_rev_o,
	output logic                            speed_fast_o,
	output logic                            busy_o,
	output logic                            home_done_o,
	output logic                            home_err_o,
	output logic                            alarm_o,
	output logic      [hms_pkg::POS_W-1:0]  pos_fb_o
);
	import hms_pkg::*;
	typedef struct packed {
		hms_state_e        st;
		logic [STEP_W-1:0] step;
		logic              lhit;
		logic [CW_W-1:0]   ctl;
		logic [METH_W-1:0] meth;
		logic              htype;
		logic [POS_W-1:0]  hoff;
		logic [POS_W-1:0]  adj;
		logic              busy;
		logic              done;
		logic              err;
		logic              alarm;
		logic              fwd;
		logic              rev;
		logic              fast;
		logic [DATA_W-1:0] rdata;
		logic [POS_W-1:0]  pos;
	} hms_regs_s;

	hms_regs_s r_reg;
	hms_regs_s r_next;
	logic [IN_W-1:0] lvl;
	logic [IN_W-1:0] rise;
	logic [IN_W-1:0] fall;
	logic            start;
	logic            frst;
	logic            rev_m;
	logic            own_lv;
	logic            own_rise;
	logic            opp_lv;
	logic            toward;
	logic            abort;
	logic            first_hit;
	logic            ev_hit;
	hms_step_s       cur;
	hms_in_sync #(
		.W(IN_W)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.raw_i    ({index_pulse_i, negative_travel_limit_i, positive_travel_limit_i, home_switch_i}),
		.lvl_o    (lvl),
		.rise_o   (rise),
		.fall_o   (fall)
	);
	// move plan per method and step
	function automatic hms_step_s step_entry(input logic [METH_W-1:0] m, input logic [STEP_W-1:0] s);
		hms_step_s e;
		e = '{fwd: 1'b0, fast: 1'b0, ev: EV_INDEX, act: ACT_HOME, nxt: 3'h0};
		case (m)
			M_HS_REV_ON: begin
				case (s)
					3'h0: e = '{1'b0, 1'b1, EV_HS_ON, ACT_SLOW, 3'h1};
					3'h1: e = '{1'b0, 1'b0, EV_HS_OFF, ACT_NEXT, 3'h2};
					3'h2: e = '{1'b1, 1'b0, EV_HS_ON, ACT_HOME, 3'h0};
					3'h3: e = '{1'b1, 1'b1, EV_HS_ON, ACT_NEXT, 3'h4};
					3'h4: e = '{1'b0, 1'b0, EV_HS_OFF, ACT_NEXT, 3'h2};
					default: e = '{1'b0, 1'b0, EV_INDEX, ACT_HOME, 3'h0};
				endcase
			end
			M_HS_REV_OFF: begin
				case (s)
					3'h0: e = '{1'b0, 1'b1, EV_HS_ON, ACT_SLOW, 3'h1};
					3'h1: e = '{1'b0, 1'b0, EV_HS_OFF, ACT_NEXT, 3'h2};
					3'h2: e = '{1'b1, 1'b0, EV_HS_ON, ACT_NEXT, 3'h3};
					3'h3: e = '{1'b0, 1'b0, EV_HS_OFF, ACT_HOME, 3'h0};
					3'h4: e = '{1'b1, 1'b1, EV_HS_ON, ACT_NEXT, 3'h3};
					default: e = '{1'b0, 1'b0, EV_INDEX, ACT_HOME, 3'h0};
				endcase
			end
			M_IDX_REV: e = '{s[0], 1'b0, EV_INDEX, ACT_HOME, 3'h0};
			M_IDX_FWD: e = '{~s[0], 1'b0, EV_INDEX, ACT_HOME, 3'h0};
			default: e = '{1'b0, 1'b0, EV_INDEX, ACT_HOME, 3'h0};
		endcase
		return e;
	endfunction
	// step that follows the first hit on the limit the method turns at
	function automatic logic [STEP_W-1:0] recover_step(input logic [METH_W-1:0] m);
		case (m)
			M_HS_REV_ON:  return 3'h3;
			M_HS_REV_OFF: return 3'h4;
			default:      return 3'h1;
		endcase
	endfunction

	assign start     = wr_i && addr_i == REG_CTRL && wdata_i[CW_W-1:0] == CW_TRIGGER && r_reg.ctl == CW_ARMED;
	assign frst      = wr_i && addr_i == REG_CTRL && wdata_i[CW_FRST_BIT] && !r_reg.ctl[CW_FRST_BIT];
	assign rev_m     = r_reg.meth != M_IDX_FWD;
	assign own_lv    = rev_m ? lvl[IN_NL] : lvl[IN_PL];
	assign own_rise  = rev_m ? rise[IN_NL] : rise[IN_PL];
	assign opp_lv    = rev_m ? lvl[IN_PL] : lvl[IN_NL];
	assign toward    = rev_m ? r_reg.rev : r_reg.fwd;
	// limits are watched in HS_HALT too, the axis still coasts; HS_FINISH does not act on them
	assign abort     = r_reg.st != HS_IDLE && (opp_lv || (r_reg.lhit && own_rise));
	assign first_hit = r_reg.st == HS_RUN && !r_reg.lhit && own_lv && toward;
	assign cur       = step_entry(r_reg.meth, r_reg.step);
	assign ev_hit    = cur.ev == EV_HS_ON ? rise[IN_HS] : (cur.ev == EV_HS_OFF ? fall[IN_HS] : rise[IN_IDX]);

	always_comb begin
		r_next       = r_reg;
		r_next.rdata = '0;
		r_next.fwd   = 1'b0;
		r_next.rev   = 1'b0;
		r_next.fast  = 1'b0;
		r_next.pos   = enc_pos_i + r_reg.adj;
		if (rd_i) begin
			case (addr_i)
				REG_CTRL:   r_next.rdata[CW_W-1:0] = r_reg.ctl;
				REG_METHOD: r_next.rdata[METH_W-1:0] = r_reg.meth;
				REG_HTYPE:  r_next.rdata[0] = r_reg.htype;
				REG_HOFFS:  r_next.rdata = r_reg.hoff;
				REG_STATUS: begin
					r_next.rdata[ST_BUSY]  = r_reg.busy;
					r_next.rdata[ST_DONE]  = r_reg.done;
					r_next.rdata[ST_ERR]   = r_reg.err;
					r_next.rdata[ST_ALARM] = r_reg.alarm;
				end
				REG_POS:    r_next.rdata = r_reg.pos;
				default:    r_next.rdata = '0;
			endcase
		end
		if (wr_i) begin
			case (addr_i)
				REG_CTRL:   r_next.ctl = wdata_i[CW_W-1:0];
				REG_METHOD: r_next.meth = r_reg.busy ? r_reg.meth : wdata_i[METH_W-1:0];
				REG_HTYPE:  r_next.htype = wdata_i[0];
				REG_HOFFS:  r_next.hoff = wdata_i;
				default:    r_next.ctl = r_reg.ctl;
			endcase
		end
		// fault reset clears first so a flag raised in the same cycle survives
		if (frst) begin
			r_next.done  = 1'b0;
			r_next.err   = 1'b0;
			r_next.alarm = 1'b0;
		end
		case (r_reg.st)
			HS_IDLE: begin
				if (start) begin
					r_next.done = 1'b0;
					r_next.err  = 1'b0;
					case (r_reg.meth)
						M_HS_REV_ON, M_HS_REV_OFF, M_IDX_REV, M_IDX_FWD: begin
							r_next.busy = 1'b1;
							r_next.lhit = 1'b0;
							r_next.st   = HS_RUN;
							r_next.step = 3'h0;
							if (lvl[IN_HS] && r_reg.meth == M_HS_REV_ON) begin
								r_next.step = 3'h1;
							end else if (lvl[IN_HS] && r_reg.meth == M_HS_REV_OFF) begin
								r_next.step = 3'h3;
							end
						end
						M_HERE: begin
							r_next.done = 1'b1;
							r_next.adj  = r_reg.htype == HT_ABS ? r_reg.hoff - enc_pos_i : r_reg.adj + r_reg.hoff;
						end
						default: r_next.err = 1'b1;
					endcase
				end
			end
			HS_RUN: begin
				if (!(abort || first_hit || (ev_hit && cur.act != ACT_SLOW))) begin
					r_next.fwd  = cur.fwd;
					r_next.rev  = !cur.fwd;
					r_next.fast = cur.fast;
				end
				if (abort) begin
					r_next.st    = HS_IDLE;
					r_next.busy  = 1'b0;
					r_next.err   = 1'b1;
					r_next.alarm = 1'b1;
				end else if (first_hit) begin
					r_next.lhit = 1'b1;
					r_next.step = recover_step(r_reg.meth);
					r_next.st   = HS_HALT;
				end else if (ev_hit) begin
					r_next.step = cur.nxt;
					if (cur.act == ACT_SLOW) begin
						r_next.fast = 1'b0;
					end else if (cur.act == ACT_HOME) begin
						r_next.st = HS_FINISH;
					end else begin
						r_next.st = HS_HALT;
					end
				end
			end
			HS_HALT: begin
				if (abort) begin
					r_next.st    = HS_IDLE;
					r_next.busy  = 1'b0;
					r_next.err   = 1'b1;
					r_next.alarm = 1'b1;
				end else if (motion_stopped_i) begin
					r_next.st = HS_RUN;
				end
			end
			HS_FINISH: begin
				// home is the stop position, so offsets apply once the axis is still
				if (motion_stopped_i) begin
					r_next.st   = HS_IDLE;
					r_next.busy = 1'b0;
					r_next.done = 1'b1;
					r_next.adj  = r_reg.htype == HT_ABS ? r_reg.hoff - enc_pos_i : r_reg.adj + r_reg.hoff;
				end
			end
			default: r_next.st = HS_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			r_reg       <= '0;
			r_reg.st    <= HS_IDLE;
			r_reg.ctl   <= CTRL_RST;
			r_reg.meth  <= METHOD_RST;
			r_reg.htype <= HTYPE_RST;
			r_reg.hoff  <= HOFFS_RST;
			r_reg.adj   <= ADJ_RST;
		end else begin
			r_reg <= r_next;
		end
	end
	assign rdata_o      = r_reg.rdata;
	assign move_fwd_o   = r_reg.fwd;
	assign move_rev_o   = r_reg.rev;
	assign speed_fast_o = r_reg.fast;
	assign busy_o       = r_reg.busy;
	assign home_done_o  = r_reg.done;
	assign home_err_o   = r_reg.err;
	assign alarm_o      = r_reg.alarm;
	assign pos_fb_o     = r_reg.pos;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_go(logic [METH_W-1:0] m);
		r_reg.st == HS_IDLE && start && r_reg.meth == m;
	endsequence
	sequence s_run(logic [METH_W-1:0] m);
		r_reg.st == HS_RUN && r_reg.meth == m && !lvl[IN_PL] && !lvl[IN_NL];
	endsequence
	sequence s_still;
		!move_fwd_o && !move_rev_o;
	endsequence
	property p_start;
		$rose(busy_o) |-> $past(start);
	endproperty
	a_start: assert property (p_start) else $error("busy rose without trigger");
	property p_pl_abort;
		r_reg.st == HS_RUN && rev_m && lvl[IN_PL] |=> alarm_o && home_err_o && !busy_o ##0 s_still;
	endproperty
	a_pl_abort: assert property (p_pl_abort) else $error("positive limit did not abort");
	property p_nl_abort;
		r_reg.st == HS_RUN && !rev_m && lvl[IN_NL] |=> alarm_o && !busy_o ##0 s_still;
	endproperty
	a_nl_abort: assert property (p_nl_abort) else $error("negative limit did not abort");
	property p_turn;
		r_reg.st == HS_RUN && rev_m && !r_reg.lhit && lvl[IN_NL] && move_rev_o && !lvl[IN_PL]
			|=> r_reg.st == HS_HALT && r_reg.lhit && !alarm_o ##0 s_still;
	endproperty
	a_turn: assert property (p_turn) else $error("no reversal at first negative limit");
	property p_abs;
		s_go(M_HERE) ##0 r_reg.htype == HT_ABS ##1 $stable(enc_pos_i) |=> pos_fb_o == $past(r_reg.hoff, 2);
	endproperty
	a_abs: assert property (p_abs) else $error("absolute home offset not loaded");
	property p_rel;
		s_go(M_HERE) ##0 r_reg.htype == HT_REL ##1 $stable(enc_pos_i)
			|=> pos_fb_o == $past(enc_pos_i) + $past(r_reg.adj, 2) + $past(r_reg.hoff, 2);
	endproperty
	a_rel: assert property (p_rel) else $error("relative home offset not added");
	property p_rsvd;
		(s_go(M_RSVD_A) or s_go(M_RSVD_B)) |=> home_err_o && !busy_o ##1 s_still;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved method started motion");
	property p_idx;
		s_run(M_IDX_REV) ##0 rise[IN_IDX] |=> r_reg.st == HS_FINISH ##0 s_still;
	endproperty
	a_idx: assert property (p_idx) else $error("index did not end search");
	property p_sw_off;
		s_run(M_HS_REV_ON) ##0 r_reg.step == 3'h1 ##0 fall[IN_HS] |=> r_reg.st == HS_HALT && r_reg.step == 3'h2;
	endproperty
	a_sw_off: assert property (p_sw_off) else $error("switch off did not stop slow reverse");
	property p_on_start;
		s_go(M_HS_REV_ON) ##0 lvl[IN_HS] |=> r_reg.step == 3'h1 ##1 move_rev_o && !speed_fast_o;
	endproperty
	a_on_start: assert property (p_on_start) else $error("switch on start not slow reverse");
	property p_done;
		r_reg.st == HS_FINISH && motion_stopped_i |=> home_done_o && !busy_o ##0 s_still;
	endproperty
	a_done: assert property (p_done) else $error("done not flagged at capture");
endmodule

// ---- hms_pkg.sv ----
// constants, register map and types for the homing sequencer
package hms_pkg;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          POS_W        = 32;
	localparam int          CW_W         = 16;
	localparam int          METH_W       = 8;
	localparam int          STEP_W       = 3;
	localparam int          IN_W         = 4;

	// register byte offsets
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_METHOD   = 8'h04;
	localparam logic [7:0]  REG_HTYPE    = 8'h08;
	localparam logic [7:0]  REG_HOFFS    = 8'h0c;
	localparam logic [7:0]  REG_STATUS   = 8'h10;
	localparam logic [7:0]  REG_POS      = 8'h14;

	// reset values
	localparam logic [15:0] CTRL_RST     = 16'h0000;
	localparam logic [7:0]  METHOD_RST   = 8'h00;
	localparam logic        HTYPE_RST    = 1'b0;
	localparam logic [31:0] HOFFS_RST    = 32'h0000_0000;
	localparam logic [31:0] ADJ_RST      = 32'h0000_0000;

	// control word values and fields
	localparam logic [15:0] CW_ARMED     = 16'h000f;
	localparam logic [15:0] CW_TRIGGER   = 16'h001f;
	localparam int          CW_FRST_BIT  = 7;

	// status bit positions
	localparam int          ST_BUSY      = 0;
	localparam int          ST_DONE      = 1;
	localparam int          ST_ERR       = 2;
	localparam int          ST_ALARM     = 3;

	// input vector lanes
	localparam int          IN_HS        = 0;
	localparam int          IN_PL        = 1;
	localparam int          IN_NL        = 2;
	localparam int          IN_IDX       = 3;

	// homing method codes
	localparam logic [7:0]  M_HS_REV_ON  = 8'h1d;
	localparam logic [7:0]  M_HS_REV_OFF = 8'h1e;
	localparam logic [7:0]  M_RSVD_A     = 8'h1f;
	localparam logic [7:0]  M_RSVD_B     = 8'h20;
	localparam logic [7:0]  M_IDX_REV    = 8'h21;
	localparam logic [7:0]  M_IDX_FWD    = 8'h22;
	localparam logic [7:0]  M_HERE       = 8'h23;

	localparam logic        HT_ABS       = 1'b0;
	localparam logic        HT_REL       = 1'b1;

	typedef enum logic [1:0] {
		HS_IDLE   = 2'b00,
		HS_RUN    = 2'b01,
		HS_HALT   = 2'b10,
		HS_FINISH = 2'b11
	} hms_state_e;

	typedef enum logic [1:0] {
		EV_HS_ON  = 2'b00,
		EV_HS_OFF = 2'b01,
		EV_INDEX  = 2'b10
	} hms_ev_e;

	typedef enum logic [1:0] {
		ACT_SLOW  = 2'b00,
		ACT_NEXT  = 2'b01,
		ACT_HOME  = 2'b10
	} hms_act_e;

	typedef struct packed {
		logic              fwd;
		logic              fast;
		hms_ev_e           ev;
		hms_act_e          act;
		logic [STEP_W-1:0] nxt;
	} hms_step_s;
endpackage

// ---- hms_in_sync.sv ----
// two-stage synchroniser with edge detection for the axis inputs
`timescale 1ns/1ns
module hms_in_sync #(
	parameter int W = 4
) (
	input  wire logic         sys_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] raw_i,
	output logic      [W-1:0] lvl_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} hms_sync_s;

	hms_sync_s r_reg;
	hms_sync_s r_next;

	// s1 feeds s2 only; edges come from s2 against s3
	always_comb begin
		r_next    = r_reg;
		r_next.s1 = raw_i;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign lvl_o  = r_reg.s2;
	assign rise_o = r_reg.s2 & ~r_reg.s3;
	assign fall_o = ~r_reg.s2 & r_reg.s3;
endmodule

// ---- hms_axis_model.sv ----
// behavioural servo axis: home switch, travel limits, index marks and encoder
`timescale 1ns/1ns
module hms_axis_model #(
	parameter int HS_LO   = 150,
	parameter int HS_HI   = 199,
	parameter int NEG_END = 0,
	parameter int POS_END = 400
) (
	input  wire logic        sys_clk_i,
	input  wire logic        load_i,
	input  wire logic [31:0] load_pos_i,
	input  wire logic        move_fwd_i,
	input  wire logic        move_rev_i,
	input  wire logic        speed_fast_i,
	output logic             home_switch_o,
	output logic             positive_travel_limit_o,
	output logic             negative_travel_limit_o,
	output logic             index_pulse_o,
	output logic             motion_stopped_o,
	output logic      [31:0] enc_pos_o
);
	int pos  = 100;
	int idle = 3;
	int step;
	always_comb step = speed_fast_i ? 4 : 1;
	always @(posedge sys_clk_i) begin
		if (load_i) begin
			pos <= $signed(load_pos_i);
		end else if (move_fwd_i && !move_rev_i) begin
			pos <= pos + step;
		end else if (move_rev_i && !move_fwd_i) begin
			pos <= pos - step;
		end
		// standstill only after two quiet cycles, so a sequencer that skips the wait moves early
		idle <= (move_fwd_i || move_rev_i) ? 0 : ((idle < 3) ? idle + 1 : idle);
	end
	assign home_switch_o           = (pos >= HS_LO) && (pos <= HS_HI);
	assign positive_travel_limit_o = pos >= POS_END;
	assign negative_travel_limit_o = pos <= NEG_END;
	// marks every 100 counts, four counts wide so a slow pass outlasts the synchroniser
	assign index_pulse_o           = (pos >= 0) && ((pos % 100) >= 50) && ((pos % 100) <= 53);
	assign motion_stopped_o        = idle >= 2;
	assign enc_pos_o               = 32'(pos);
endmodule

// ---- hms_tb.sv ----
// self-checking bench for the homing sequencer against a behavioural axis
`timescale 1ns/1ns
module testbench
	import hms_pkg::*;
;
	logic              sys_clk_i = 1'b0;
	logic              sys_rst_i = 1'b1;
	logic [ADDR_W-1:0] addr_i    = '0;
	logic [DATA_W-1:0] wdata_i   = '0;
	logic              wr_i      = 1'b0;
	logic              rd_i      = 1'b0;
	logic [DATA_W-1:0] rdata_o;
	logic              hs;
	logic              pl;
	logic              nl;
	logic              idx;
	logic              stopped;
	logic              fwd;
	logic              rev;
	logic              fast;
	logic              busy;
	logic              done;
	logic              err;
	logic              alarm;
	logic [POS_W-1:0]  enc_pos;
	logic [POS_W-1:0]  pos_fb;
	logic              load      = 1'b0;
	logic [31:0]       load_pos  = '0;
	int                error_cnt = 0;
	int                checks_done = 0;

	hms_homing DUT (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .home_switch_i(hs),
		.positive_travel_limit_i(pl), .negative_travel_limit_i(nl), .index_pulse_i(idx),
		.motion_stopped_i(stopped), .enc_pos_i(enc_pos), .move_fwd_o(fwd), .move_rev_o(rev),
		.speed_fast_o(fast), .busy_o(busy), .home_done_o(done), .home_err_o(err),
		.alarm_o(alarm), .pos_fb_o(pos_fb)
	);
	hms_axis_model u_axis (
		.sys_clk_i(sys_clk_i), .load_i(load), .load_pos_i(load_pos), .move_fwd_i(fwd),
		.move_rev_i(rev), .speed_fast_i(fast), .home_switch_o(hs), .positive_travel_limit_o(pl),
		.negative_travel_limit_o(nl), .index_pulse_o(idx), .motion_stopped_o(stopped),
		.enc_pos_o(enc_pos)
	);

	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge sys_clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		checks_done++;
		if (rdata_o !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, rdata_o);
			error_cnt++;
		end
	endtask

	task automatic chk_rng(input string name, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			$display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
			error_cnt++;
		end
	endtask

	// pins are read a full cycle after they settle, so no edge race
	task automatic chk_pin(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask

	// place the axis, clear faults, arm and trigger, then judge status and resting place
	task automatic run_case(input logic [7:0] meth, input int start, input int lo, input int hi,
		input logic [3:0] st);
		int n;
		@(posedge sys_clk_i);
		load     <= 1'b1;
		load_pos <= 32'(start);
		@(posedge sys_clk_i);
		load <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		bus_wr(REG_CTRL, 32'h80);
		bus_wr(REG_METHOD, {24'h0, meth});
		bus_wr(REG_CTRL, {16'h0, CW_ARMED});
		bus_wr(REG_CTRL, {16'h0, CW_TRIGGER});
		@(posedge sys_clk_i);
		n = 0;
		while (done !== 1'b1 && err !== 1'b1 && n < 5000) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (n >= 5000) begin
			$display("BAD completion expected done seen timeout");
			error_cnt++;
			summarize();
		end
		repeat (4) @(posedge sys_clk_i);
		rd_chk(REG_STATUS, {28'h0, st}, "status");
		chk_pin("status pins", {28'h0, st}, {28'h0, alarm, err, done, busy});
		chk_pin("motion pins", 32'h0, {29'h0, fwd, rev, fast});
		chk_rng("resting position", lo, hi, $signed(enc_pos));
		$display("test method %0d from %0d finished", meth, start);
	endtask

	initial begin
		int a;
		repeat (3) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		for (a = 0; a <= 8'h18; a += 4) begin
			if (a != 8'h14) begin
				rd_chk(8'(a), 32'h0, "reset value");
			end
		end
		rd_chk(REG_POS, 32'h64, "position after reset");
		bus_wr(REG_STATUS, 32'hf);
		rd_chk(REG_STATUS, 32'h0, "read-only status");
		bus_wr(REG_METHOD, {24'h0, M_IDX_REV});
		rd_chk(REG_METHOD, {24'h0, M_IDX_REV}, "method readback");
		$display("test registers finished");
		bus_wr(REG_HTYPE, {31'h0, HT_ABS});
		bus_wr(REG_HOFFS, 32'h100);
		run_case(M_HERE, 77, 77, 77, 4'b0010);
		rd_chk(REG_POS, 32'h100, "absolute home");
		chk_pin("position feedback", 32'h100, pos_fb);
		bus_wr(REG_HTYPE, {31'h0, HT_REL});
		bus_wr(REG_HOFFS, 32'h10);
		run_case(M_HERE, 77, 77, 77, 4'b0010);
		rd_chk(REG_POS, 32'h110, "relative home");
		chk_pin("position feedback", 32'h110, pos_fb);
		bus_wr(REG_HOFFS, 32'h0);
		bus_wr(REG_CTRL, 32'h80);
		bus_wr(REG_CTRL, {16'h0, CW_TRIGGER});
		repeat (3) @(posedge sys_clk_i);
		rd_chk(REG_STATUS, 32'h0, "trigger without arming");
		$display("test trigger finished");
		run_case(M_RSVD_A, 100, 100, 100, 4'b0100);
		run_case(M_RSVD_B, 100, 100, 100, 4'b0100);
		run_case(M_HS_REV_ON, 250, 150, 157, 4'b0010);
		run_case(M_HS_REV_ON, 100, 150, 157, 4'b0010);
		run_case(M_HS_REV_ON, 170, 150, 157, 4'b0010);
		run_case(M_HS_REV_OFF, 250, 142, 149, 4'b0010);
		run_case(M_HS_REV_OFF, 100, 142, 149, 4'b0010);
		run_case(M_HS_REV_OFF, 170, 142, 149, 4'b0010);
		run_case(M_IDX_REV, 120, 46, 53, 4'b0010);
		run_case(M_IDX_REV, 30, 50, 57, 4'b0010);
		run_case(M_IDX_FWD, 300, 350, 357, 4'b0010);
		run_case(M_IDX_FWD, 370, 346, 353, 4'b0010);
		run_case(M_HS_REV_ON, 410, 402, 418, 4'b1100);
		run_case(M_HS_REV_OFF, 410, 402, 418, 4'b1100);
		run_case(M_IDX_REV, 410, 402, 418, 4'b1100);
		run_case(M_IDX_FWD, -10, -18, -2, 4'b1100);
		summarize();
	end
endmodule
